// ---- rtl/asc_defs.svh ----
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// Register offsets and reset values
`define ASC_ADDR_CTRL_ONE 8'h2A
`define ASC_ADDR_CTRL_TWO 8'h2B
`define ASC_CTRL_ONE_RESET 8'h00
`define ASC_CTRL_TWO_RESET 8'h00
// Writable and readable bits; unused bits and the reset bit read zero
`define ASC_CTRL_ONE_MASK 8'hFB
`define ASC_CTRL_TWO_MASK 8'h9F

// Field positions, first control register
`define ASC_SLEEP_RATE_MSB 7
`define ASC_SLEEP_RATE_LSB 6
`define ASC_WAKE_RATE_MSB 5
`define ASC_WAKE_RATE_LSB 3
`define ASC_FAST_READ_BIT 1
`define ASC_ACTIVE_BIT 0

// Field positions, second control register
`define ASC_SELF_TEST_BIT 7
`define ASC_SOFT_RESET_BIT 6
`define ASC_SLEEP_PWR_MSB 4
`define ASC_SLEEP_PWR_LSB 3
`define ASC_AUTO_SLEEP_BIT 2
`define ASC_WAKE_PWR_MSB 1
`define ASC_WAKE_PWR_LSB 0

// Output data block walked by the read pointer
`define ASC_ADDR_OUT_FIRST 8'h01
`define ASC_ADDR_OUT_LAST 8'h06
`define ASC_ADDR_WRAP 8'h00
`define ASC_FIFO_BYTES_FULL 3'h6
`define ASC_FIFO_BYTES_FAST 3'h3
`define ASC_FIFO_MODE_OFF 2'h0

// Timing
`define ASC_CLK_PERIOD_NS 4
`define ASC_BOOT_TIME_NS 64
`define ASC_BOOT_CYCLES \
	((`ASC_BOOT_TIME_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_BASE_PERIOD_NS 1250000
`define ASC_BASE_CYCLES (`ASC_BASE_PERIOD_NS / `ASC_CLK_PERIOD_NS)

// Sample period as a multiple of the 1.25 ms base period
`define ASC_MULT_800 14'h0001
`define ASC_MULT_400 14'h0002
`define ASC_MULT_200 14'h0004
`define ASC_MULT_100 14'h0008
`define ASC_MULT_50 14'h0010
`define ASC_MULT_12P5 14'h0040
`define ASC_MULT_6P25 14'h0080
`define ASC_MULT_1P56 14'h0200
`define ASC_MULT_0P05 14'h3E80

`endif

// ---- rtl/asc_pkg.sv ----
package asc_pkg;

	typedef enum logic [1:0] {
		ASC_ST_STANDBY = 2'b00,
		ASC_ST_WAKE = 2'b01,
		ASC_ST_SLEEP = 2'b10
	} asc_mode_t;

	typedef enum logic [1:0] {
		ASC_PWR_NORMAL = 2'b00,
		ASC_PWR_LNLP = 2'b01,
		ASC_PWR_HIRES = 2'b10,
		ASC_PWR_LOW = 2'b11
	} asc_power_t;

	typedef enum logic [3:0] {
		ASC_ODR_800 = 4'b0000,
		ASC_ODR_400 = 4'b0001,
		ASC_ODR_200 = 4'b0010,
		ASC_ODR_100 = 4'b0011,
		ASC_ODR_50 = 4'b0100,
		ASC_ODR_12P5 = 4'b0101,
		ASC_ODR_6P25 = 4'b0110,
		ASC_ODR_1P56 = 4'b0111,
		ASC_ODR_0P05 = 4'b1000
	} asc_rate_t;

endpackage : asc_pkg

// ---- rtl/asc_rate_if.sv ----
interface asc_rate_if;
	logic run;
	asc_pkg::asc_rate_t code;
	logic tick;

	modport ctrl (output run, output code, input tick);
	modport gen (input run, input code, output tick);
endinterface : asc_rate_if

// ---- rtl/asc_rate_gen.sv ----
`include "asc_defs.svh"

module asc_rate_gen #(
	parameter int unsigned P_BASE_CYCLES = `ASC_BASE_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	asc_rate_if.gen rate
);
	import asc_pkg::*;

	function automatic logic [13:0] mult_of(input asc_rate_t code);
		case (code)
			ASC_ODR_800: mult_of = `ASC_MULT_800;
			ASC_ODR_400: mult_of = `ASC_MULT_400;
			ASC_ODR_200: mult_of = `ASC_MULT_200;
			ASC_ODR_100: mult_of = `ASC_MULT_100;
			ASC_ODR_50: mult_of = `ASC_MULT_50;
			ASC_ODR_12P5: mult_of = `ASC_MULT_12P5;
			ASC_ODR_6P25: mult_of = `ASC_MULT_6P25;
			ASC_ODR_1P56: mult_of = `ASC_MULT_1P56;
			default: mult_of = `ASC_MULT_0P05;
		endcase
	endfunction : mult_of

	logic [31:0] pre_reg, pre_next;
	logic [13:0] mul_reg, mul_next;
	asc_rate_t code_reg, code_next;
	logic tick_reg, tick_next;

	always_comb begin
		pre_next = pre_reg;
		mul_next = mul_reg;
		code_next = rate.code;
		tick_next = 1'b0;
		// Rate change restarts the period so no short sample slips out
		if (!rate.run || rate.code != code_reg) begin
			pre_next = 32'h00000000;
			mul_next = 14'h0000;
		end else if (pre_reg == P_BASE_CYCLES - 1) begin
			pre_next = 32'h00000000;
			if (mul_reg == mult_of(code_reg) - 14'h0001) begin
				mul_next = 14'h0000;
				tick_next = 1'b1;
			end else begin
				mul_next = mul_reg + 14'h0001;
			end
		end else begin
			pre_next = pre_reg + 32'h00000001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pre_reg <= 32'h00000000;
			mul_reg <= 14'h0000;
			code_reg <= ASC_ODR_800;
			tick_reg <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			mul_reg <= mul_next;
			code_reg <= code_next;
			tick_reg <= tick_next;
		end
	end

	assign rate.tick = tick_reg;

endmodule : asc_rate_gen

// ---- rtl/asc_system_control.sv ----
// The plain strobed port was chosen for this implementation.
`include "asc_defs.svh"

// Operation
// - Bits 7-6 pick sleep sampling rate
// - Sleep rate overrides all rates while asleep
// - Bits 5-3 pick wake data rate
// - Bit 0 selects standby or active
// - Fast read skips low output bytes from an odd address until the wrap to 00
// - Fast read drops low FIFO bytes
// - Bit 7 of second enables self-test
// - Reset bit reloads all register defaults
// - Software reset also resets serial logic
// - Reset bit self-clears, always reads zero
// - Bit 2 of second enables auto-sleep
// - Bits 1-0 pick wake power scheme
// - Bits 4-3 pick sleep power scheme
// - Power schemes share one encoding
// - Rate switching only with auto-sleep enabled
// - Without auto-sleep never enter sleep
module asc_system_control #(
	parameter int unsigned P_BASE_CYCLES = `ASC_BASE_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic [1:0] i_fifo_mode,
	input wire logic i_sleep_req,
	input wire logic i_wake_req,
	input wire logic i_ptr_step,
	input wire logic [7:0] i_ptr_addr,
	output logic [7:0] o_ptr_next,
	output logic o_active,
	output logic o_asleep,
	output asc_pkg::asc_rate_t o_eff_rate,
	output asc_pkg::asc_power_t o_eff_power,
	output logic o_fast_read,
	output logic [2:0] o_fifo_bytes,
	output logic o_self_test,
	output logic o_auto_sleep_en,
	output logic o_comm_reset,
	output logic o_sample_tick
);
	import asc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	function automatic asc_rate_t sleep_rate_of(input logic [1:0] sel);
		case (sel)
			2'b00: sleep_rate_of = ASC_ODR_50;
			2'b01: sleep_rate_of = ASC_ODR_12P5;
			2'b10: sleep_rate_of = ASC_ODR_0P05;
			default: sleep_rate_of = ASC_ODR_1P56;
		endcase
	endfunction : sleep_rate_of

	function automatic asc_rate_t wake_rate_of(input logic [2:0] sel);
		wake_rate_of = asc_rate_t'({1'b0, sel});
	endfunction : wake_rate_of

	// Next address of a multi-byte read in the output data block
	function automatic logic [7:0] next_addr(input logic [7:0] addr,
			input logic fast);
		logic [7:0] step;
		// Outside the output block the pointer walks on unchecked
		step = fast ? 8'h02 : 8'h01;
		next_addr = addr + step;
		if (addr >= `ASC_ADDR_OUT_FIRST && addr <= `ASC_ADDR_OUT_LAST) begin
			if (addr + step > `ASC_ADDR_OUT_LAST) begin
				next_addr = `ASC_ADDR_WRAP;
			end
		end
	endfunction : next_addr

	////////////////////////////////////////////////////////////////////////
	// State

	logic [7:0] ctrl_one_reg, ctrl_one_next;
	logic [7:0] ctrl_two_reg, ctrl_two_next;
	asc_mode_t mode_reg, mode_next;
	logic [4:0] boot_reg, boot_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] ptr_reg, ptr_next;
	asc_rate_t rate_reg, rate_next;
	asc_power_t power_reg, power_next;
	logic [2:0] fbytes_reg, fbytes_next;
	logic comm_rst_reg, comm_rst_next;
	logic tick_reg;
	// Registered copy so the sleep flag leaves a flip-flop
	logic asleep_reg, asleep_next;

	logic wr_one, wr_two, rd_one, rd_two;
	logic booting;
	logic active_bit, aslp_en;

	asc_rate_if rate_bus ();

	always_comb begin
		wr_one = 1'b0;
		wr_two = 1'b0;
		rd_one = 1'b0;
		rd_two = 1'b0;
		// Unmapped addresses fall through: reads give zero, writes vanish
		if (i_addr == `ASC_ADDR_CTRL_ONE) begin
			wr_one = i_wr;
			rd_one = i_rd;
		end else if (i_addr == `ASC_ADDR_CTRL_TWO) begin
			wr_two = i_wr;
			rd_two = i_rd;
		end
	end

	assign booting = (boot_reg != 5'h00);
	assign active_bit = ctrl_one_reg[`ASC_ACTIVE_BIT];
	assign aslp_en = ctrl_two_reg[`ASC_AUTO_SLEEP_BIT];

	////////////////////////////////////////////////////////////////////////
	// Register file and software reset

	always_comb begin
		ctrl_one_next = ctrl_one_reg;
		ctrl_two_next = ctrl_two_reg;
		boot_next = boot_reg;
		comm_rst_next = 1'b0;
		if (booting) begin
			// Boot in progress: fields held at defaults, accesses dropped
			boot_next = boot_reg - 5'h01;
			comm_rst_next = (boot_reg != 5'h01);
		end else if (wr_two && i_wdata[`ASC_SOFT_RESET_BIT]) begin
			// Other bits written alongside the reset bit are dropped
			ctrl_one_next = `ASC_CTRL_ONE_RESET;
			ctrl_two_next = `ASC_CTRL_TWO_RESET;
			boot_next = 5'(`ASC_BOOT_CYCLES);
			comm_rst_next = 1'b1;
		end else if (wr_one) begin
			if (active_bit) begin
				// Other fields are frozen while sampling
				ctrl_one_next[`ASC_ACTIVE_BIT] = i_wdata[`ASC_ACTIVE_BIT];
			end else begin
				ctrl_one_next = i_wdata & `ASC_CTRL_ONE_MASK;
				if (i_fifo_mode != `ASC_FIFO_MODE_OFF) begin
					ctrl_one_next[`ASC_FAST_READ_BIT] =
						ctrl_one_reg[`ASC_FAST_READ_BIT];
				end
			end
		end else if (wr_two) begin
			ctrl_two_next = i_wdata & `ASC_CTRL_TWO_MASK;
		end
	end

	// Read data for one cycle only; the reset bit is never stored
	always_comb begin
		rdata_next = 8'h00;
		if (!booting) begin
			if (rd_one) begin
				rdata_next = ctrl_one_reg & `ASC_CTRL_ONE_MASK;
			end else if (rd_two) begin
				rdata_next = ctrl_two_reg & `ASC_CTRL_TWO_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operating mode

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			ASC_ST_STANDBY: begin
				if (active_bit) begin
					mode_next = ASC_ST_WAKE;
				end
			end
			ASC_ST_WAKE: begin
				if (!active_bit) begin
					mode_next = ASC_ST_STANDBY;
				end else if (aslp_en && i_sleep_req) begin
					mode_next = ASC_ST_SLEEP;
				end
			end
			ASC_ST_SLEEP: begin
				if (!active_bit) begin
					mode_next = ASC_ST_STANDBY;
				end else if (!aslp_en || i_wake_req) begin
					mode_next = ASC_ST_WAKE;
				end
			end
			default: begin
				mode_next = ASC_ST_STANDBY;
			end
		endcase
		if (booting) begin
			mode_next = ASC_ST_STANDBY;
		end
		// Same edge as the mode register, so no extra latency
		asleep_next = (mode_next == ASC_ST_SLEEP);
	end

	////////////////////////////////////////////////////////////////////////
	// Effective rate, power scheme and read shaping

	always_comb begin
		// Standby and wake both show the wake fields
		rate_next = wake_rate_of(
			ctrl_one_reg[`ASC_WAKE_RATE_MSB:`ASC_WAKE_RATE_LSB]);
		power_next = asc_power_t'(
			ctrl_two_reg[`ASC_WAKE_PWR_MSB:`ASC_WAKE_PWR_LSB]);
		if (mode_reg == ASC_ST_SLEEP) begin
			rate_next = sleep_rate_of(
				ctrl_one_reg[`ASC_SLEEP_RATE_MSB:`ASC_SLEEP_RATE_LSB]);
			power_next = asc_power_t'(
				ctrl_two_reg[`ASC_SLEEP_PWR_MSB:`ASC_SLEEP_PWR_LSB]);
		end
	end

	always_comb begin
		fbytes_next = `ASC_FIFO_BYTES_FULL;
		if (ctrl_one_reg[`ASC_FAST_READ_BIT]) begin
			fbytes_next = `ASC_FIFO_BYTES_FAST;
		end
		ptr_next = ptr_reg;
		if (booting) begin
			// A pointer left mid-transfer must not outlive the reset
			ptr_next = `ASC_ADDR_WRAP;
		end else if (i_ptr_step) begin
			// Fast read steps over the low bytes from an odd address until the wrap to 00
			ptr_next = next_addr(i_ptr_addr,
				ctrl_one_reg[`ASC_FAST_READ_BIT]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample clock follows the selected rate

	assign rate_bus.run = (mode_reg != ASC_ST_STANDBY);
	assign rate_bus.code = rate_reg;

	asc_rate_gen #(
		.P_BASE_CYCLES(P_BASE_CYCLES)
	) u_rate_gen (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.rate(rate_bus.gen)
	);

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ctrl_one_reg <= `ASC_CTRL_ONE_RESET;
			ctrl_two_reg <= `ASC_CTRL_TWO_RESET;
			mode_reg <= ASC_ST_STANDBY;
			boot_reg <= 5'h00;
			rdata_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rate_reg <= ASC_ODR_800;
			power_reg <= ASC_PWR_NORMAL;
			fbytes_reg <= `ASC_FIFO_BYTES_FULL;
			comm_rst_reg <= 1'b0;
			tick_reg <= 1'b0;
			asleep_reg <= 1'b0;
		end else begin
			ctrl_one_reg <= ctrl_one_next;
			ctrl_two_reg <= ctrl_two_next;
			mode_reg <= mode_next;
			boot_reg <= boot_next;
			rdata_reg <= rdata_next;
			ptr_reg <= ptr_next;
			rate_reg <= rate_next;
			power_reg <= power_next;
			fbytes_reg <= fbytes_next;
			comm_rst_reg <= comm_rst_next;
			tick_reg <= rate_bus.tick;
			asleep_reg <= asleep_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_rdata = rdata_reg;
	assign o_ptr_next = ptr_reg;
	assign o_active = active_bit;
	// No decode here: every output is a register bit
	assign o_asleep = asleep_reg;
	assign o_eff_rate = rate_reg;
	assign o_eff_power = power_reg;
	assign o_fast_read = ctrl_one_reg[`ASC_FAST_READ_BIT];
	assign o_fifo_bytes = fbytes_reg;
	assign o_self_test = ctrl_two_reg[`ASC_SELF_TEST_BIT];
	assign o_auto_sleep_en = aslp_en;
	assign o_comm_reset = comm_rst_reg;
	assign o_sample_tick = tick_reg;

endmodule : asc_system_control

// ---- test/asc_chk.sv ----
module asc_chk (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_ptr_step,
	input wire logic [7:0] i_ptr_addr,
	input wire logic [7:0] o_ptr_next,
	input wire logic o_active,
	input wire logic o_asleep,
	input wire logic o_fast_read,
	input wire logic o_self_test,
	input wire logic o_auto_sleep_en,
	input wire logic o_comm_reset,
	input wire logic o_sample_tick
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////
	a_active_bit: assert property (
		i_wr && i_addr == 8'h2A && !o_comm_reset
		|=> o_active == $past(i_wdata[0])) else $error("active bit");
	a_unused_zero: assert property (
		i_rd && i_addr == 8'h2A |=> !o_rdata[2]) else $error("bit 2");
	a_rst_bit_zero: assert property (
		i_rd && i_addr == 8'h2B |=> o_rdata[6:5] == 2'h0)
		else $error("reset bit read");
	a_soft_reset: assert property (
		i_wr && i_addr == 8'h2B && i_wdata[6] && !o_comm_reset
		|=> o_comm_reset && !o_active && !o_self_test
		&& !o_auto_sleep_en && !o_fast_read) else $error("soft reset");
	a_boot_len: assert property (
		$rose(o_comm_reset) |-> ##15 o_comm_reset ##1 !o_comm_reset)
		else $error("boot length");
	a_boot_quiet: assert property (
		o_comm_reset && i_rd |=> o_rdata == 8'h00)
		else $error("read in boot");
	a_no_sleep: assert property (
		!o_auto_sleep_en && !o_asleep |=> !o_asleep)
		else $error("sleep entered");
	a_ptr_normal: assert property (
		i_ptr_step && !o_comm_reset && !o_fast_read && i_ptr_addr < 8'h06
		|=> o_ptr_next == $past(i_ptr_addr) + 8'h01)
		else $error("pointer step");
	a_ptr_fast: assert property (
		i_ptr_step && !o_comm_reset && o_fast_read && i_ptr_addr == 8'h05
		|=> o_ptr_next == 8'h00) else $error("fast wrap");
	a_idle_tick: assert property (
		(!o_active)[*4] |-> !o_sample_tick) else $error("tick in standby");
	c_sleep: cover property ($rose(o_asleep));
	c_boot: cover property ($rose(o_comm_reset));
	c_fast: cover property (i_ptr_step && o_fast_read);
endmodule : asc_chk

bind asc_system_control asc_chk chk_u (.*);

// ---- test/asc_host.sv ----
module asc_host (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// Caller settles standby and FIFO mode before field writes
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1 d = i_rdata;
	endtask : rd
endmodule : asc_host

// ---- test/tb_top.sv ----
`define CHK(g, e) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("mismatch t=%0t got %0h exp %0h", $time, g, e); \
	end \
end

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import asc_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_sleep_req = 1'b0, i_wake_req = 1'b0, i_ptr_step = 1'b0;
	logic [7:0] i_ptr_addr = 8'h00;
	logic [1:0] i_fifo_mode = 2'h0;
	logic [7:0] i_addr, i_wdata, o_rdata, o_ptr_next, d;
	logic i_wr, i_rd, o_active, o_asleep, o_fast_read, o_self_test;
	logic o_auto_sleep_en, o_comm_reset, o_sample_tick;
	logic [2:0] o_fifo_bytes;
	asc_rate_t o_eff_rate;
	asc_power_t o_eff_power;
	int fail_count = 0, num_checks = 0, n;
	localparam asc_rate_t SLP[4] = '{ASC_ODR_50, ASC_ODR_12P5,
		ASC_ODR_0P05, ASC_ODR_1P56};

	always #2 i_clk = ~i_clk;

	asc_host host_u (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
		.o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
	// Short base period keeps tick counts in reach
	asc_system_control #(.P_BASE_CYCLES(4)) dut_u (.*);

	////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	task wait_c(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask : wait_c
	task rchk(input logic [7:0] a, input logic [7:0] e);
		host_u.rd(a, d);
		`CHK(d, e)
	endtask : rchk
	task req(input bit s);
		@(posedge i_clk);
		i_sleep_req <= s;
		i_wake_req <= !s;
		@(posedge i_clk);
		i_sleep_req <= 1'b0;
		i_wake_req <= 1'b0;
	endtask : req
	task step(input logic [7:0] a);
		@(posedge i_clk);
		i_ptr_step <= 1'b1;
		i_ptr_addr <= a;
		@(posedge i_clk);
		i_ptr_step <= 1'b0;
		#1;
	endtask : step
	task ticks(input int e);
		n = 0;
		while (o_sample_tick !== 1'b1 && n < 400) begin
			@(posedge i_clk);
			#1 n++;
		end
		if (n >= 400) begin
			fail_count++;
			end_of_test;
		end else begin
			n = 0;
			repeat (64) begin
				@(posedge i_clk);
				#1 if (o_sample_tick === 1'b1) n++;
			end
			`CHK(n, e)
		end
	endtask : ticks

	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rchk(8'h2A, 8'h00);
		rchk(8'h2B, 8'h00);
		host_u.wr(8'h2A, 8'hFF);
		rchk(8'h2A, 8'hFB);
		host_u.wr(8'h2A, 8'h00);
		rchk(8'h2A, 8'hFA);
		host_u.wr(8'h2A, 8'h00);
		host_u.wr(8'h2B, 8'hAF);
		rchk(8'h2B, 8'h8F);
		`CHK(o_self_test, 1'b1)
		`CHK(o_auto_sleep_en, 1'b1)
		`CHK(o_eff_power, ASC_PWR_LOW)
		$display("test registers done");
		host_u.wr(8'h2B, 8'h14);
		for (int c = 0; c < 8; c++) begin
			host_u.wr(8'h2A, 8'h00);
			host_u.wr(8'h2A, {2'h0, c[2:0], 3'h1});
			wait_c(3);
			`CHK(o_eff_rate, asc_rate_t'(c))
			`CHK(o_eff_power, ASC_PWR_NORMAL)
			if (c < 5)
				ticks(16 >> c);
		end
		$display("test wake rates done");
		for (int s = 0; s < 4; s++) begin
			host_u.wr(8'h2A, 8'h00);
			host_u.wr(8'h2A, {s[1:0], 6'h01});
			wait_c(2);
			req(1'b1);
			wait_c(3);
			`CHK(o_asleep, 1'b1)
			`CHK(o_eff_rate, SLP[s])
			`CHK(o_eff_power, ASC_PWR_HIRES)
			req(1'b0);
			wait_c(3);
			`CHK(o_asleep, 1'b0)
		end
		host_u.wr(8'h2B, 8'h10);
		req(1'b1);
		wait_c(3);
		`CHK(o_asleep, 1'b0)
		$display("test sleep done");
		host_u.wr(8'h2A, 8'h00);
		@(posedge i_clk);
		i_fifo_mode <= 2'h1;
		host_u.wr(8'h2A, 8'h02);
		rchk(8'h2A, 8'h00);
		@(posedge i_clk);
		i_fifo_mode <= 2'h0;
		host_u.wr(8'h2A, 8'h02);
		rchk(8'h2A, 8'h02);
		`CHK(o_fifo_bytes, 3'h3)
		`CHK(o_fast_read, 1'b1)
		step(8'h01);
		`CHK(o_ptr_next, 8'h03)
		step(8'h05);
		`CHK(o_ptr_next, 8'h00)
		host_u.wr(8'h2A, 8'h00);
		wait_c(2);
		`CHK(o_fifo_bytes, 3'h6)
		step(8'h03);
		`CHK(o_ptr_next, 8'h04)
		$display("test fast read done");
		host_u.wr(8'h2B, 8'h84);
		host_u.wr(8'h2A, 8'hF9);
		host_u.wr(8'h2B, 8'h40);
		wait_c(0);
		`CHK(o_comm_reset, 1'b1)
		`CHK(o_active, 1'b0)
		rchk(8'h2A, 8'h00);
		wait_c(20);
		`CHK(o_comm_reset, 1'b0)
		rchk(8'h2A, 8'h00);
		rchk(8'h2B, 8'h00);
		$display("test soft reset done");
		end_of_test;
	end
endmodule : tb_top
